// *** hw/bpcc_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the bridge configuration block.
`ifndef BPCC_DEFS_SVH
`define BPCC_DEFS_SVH
`define BPCC_OFF_LEGACY 8'h40
`define BPCC_OFF_MISC 8'h44
`define BPCC_OFF_STRAP 8'h48
`define BPCC_OFF_PREFETCH 8'h4c
`define BPCC_OFF_RISE 8'h50
`define BPCC_OFF_FALL 8'h54
`define BPCC_RST_MISC 32'h0000_0000
`define BPCC_RST_PREFETCH 14'h2c00
`define BPCC_RST_LEGACY_MODE 1'b1
`define BPCC_BUFFER_DELAY_VALUE_LSB 8
`define BPCC_HPB_BIT 3
`define BPCC_HPA_BIT 2
`define BPCC_CALC_LSB 16
`define BPCC_MODE_B_LSB 13
`define BPCC_VAL_B_LSB 8
`define BPCC_MODE_A_LSB 5
`define BPCC_VAL_A_LSB 0
`define BPCC_TOP_BIT 31
`define BPCC_PF_CPF_MULTI 13
`define BPCC_PF_IPF_MULTI 10
`define BPCC_PF_CPF_LINE 9
`define BPCC_PF_IPF_LINE 6
`define BPCC_PF_CPF_PLAIN 5
`define BPCC_PF_IPF_PLAIN 2
`define BPCC_PF_DISCARD_ON_MASTER_REQ 1
`define BPCC_PF_DISCARD_ON_HOST_REQ 0
`define BPCC_DISCARD_SHORT 16'h0010
`define BPCC_DISCARD_LONG 16'h8000
`define BPCC_DRIVE_MAX 4'hf
`define BPCC_PEND_MAX 4'hf
`endif

// *** hw/bpcc_pkg.sv ***
// Types shared by the bridge configuration block.
package bpcc_pkg;
   typedef enum logic [1:0] {
      BPCC_CMD_PLAIN = 2'h0,
      BPCC_CMD_LINE = 2'h1,
      BPCC_CMD_MULTI = 2'h3,
      BPCC_CMD_OTHER = 2'h2
   } bpcc_cmd_t;

   typedef struct packed {
      logic [3:0] calc_fall;
      logic [3:0] calc_rise;
      logic serr_n;
      logic perr_n;
      logic [3:0] irq_n;
      logic compat;
      logic hp_a;
      logic hp_b;
      logic [3:0] buffer_delay_value;
      logic power_good;
   } bpcc_pins_t;

   typedef struct packed {
      logic line_req;
      logic discard_unreq;
      logic discard_all;
      logic burst_stop;
   } bpcc_pf_out_t;

   typedef struct packed {
      bpcc_pins_t sync1;
      bpcc_pins_t sync2;
      logic pg_prev;
      logic perr_prev;
      logic serr_prev;
      logic legacy_mode;
      logic [31:0] misc;
      logic [3:0] buffer_delay_value;
      logic hp_b;
      logic hp_a;
      logic compat;
      logic [13:0] pf;
      logic [1:0] top;
      logic [1:0][1:0] mode_b;
      logic [1:0][3:0] val_b;
      logic [1:0][1:0] mode_a;
      logic [1:0][3:0] val_a;
      logic pf_active;
      logic pf_cont;
      logic [3:0] pf_pending;
      logic [15:0] pf_timer;
      logic pf_short_done;
      logic host_wait_disc;
      logic host_wait_bound;
      logic [31:0] rdata;
      logic [3:0] irq_oe;
      logic [3:0] irq_out_n;
      logic nmi;
      logic compat_fwd;
      bpcc_pf_out_t pfo;
      logic [1:0][1:0][3:0] drive;
   } bpcc_state_t;
endpackage

// *** hw/bpcc_top.sv ***
// Bridge configuration registers, legacy interrupt combining, prefetch policy and drive compensation.
`timescale 1ns/1ps
`include "bpcc_defs.svh"
module bpcc_top #(
   parameter logic [15:0] DISCARD_LONG = `BPCC_DISCARD_LONG
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic power_good,
   input wire logic [3:0] buffer_delay_strap,
   input wire logic hotplug_strap_b,
   input wire logic hotplug_strap_a,
   input wire logic compat_strap,
   input wire logic [3:0] pci_irq_in_n,
   input wire logic [3:0] redir_mask_bit,
   input wire logic [3:0] peer_irq_req,
   output logic [3:0] legacy_irq_out_n,
   output logic [3:0] legacy_irq_oe,
   input wire logic perr_n,
   input wire logic serr_n,
   output logic error_nmi,
   input wire logic host_compat_req,
   output logic compat_fwd,
   input wire logic conv_pci_mode,
   input wire logic [4:0] master_prefetch_dis,
   input wire logic rd_start,
   input wire bpcc_pkg::bpcc_cmd_t rd_cmd,
   input wire logic [2:0] rd_master,
   input wire logic line_xfer_start,
   input wire logic bus_clk_tick,
   input wire logic other_master_req,
   input wire logic host_req,
   input wire logic burst_active,
   input wire logic requested_outstanding,
   input wire logic burst_disconnect,
   input wire logic line_boundary,
   output bpcc_pkg::bpcc_pf_out_t pf_out,
   input wire logic [3:0] calc_drive_rise,
   input wire logic [3:0] calc_drive_fall,
   output logic [3:0] drive_rise_a,
   output logic [3:0] drive_rise_b,
   output logic [3:0] drive_fall_a,
   output logic [3:0] drive_fall_b
);
   bpcc_pkg::bpcc_state_t st_reg;
   bpcc_pkg::bpcc_state_t st_next;
   bpcc_pkg::bpcc_pins_t pins_raw;
   bpcc_pkg::bpcc_pins_t pin_s;
   logic [1:0][1:0][3:0] drive_calc;
   logic [1:0][3:0] calc_s;
   logic legacy_mode;
   logic error_nmi_en;
   logic discard_on_master_req;
   logic discard_on_host_req;
   logic master_ok;
   logic [2:0] init_sel;
   logic cont_sel;
   logic pf_stop;

   assign pins_raw = '{calc_fall: calc_drive_fall, calc_rise: calc_drive_rise, serr_n: serr_n,
                       perr_n: perr_n, irq_n: pci_irq_in_n, compat: compat_strap,
                       hp_a: hotplug_strap_a, hp_b: hotplug_strap_b, buffer_delay_value: buffer_delay_strap,
                       power_good: power_good};
   assign pin_s = st_reg.sync2;
   assign calc_s = {pin_s.calc_fall, pin_s.calc_rise};
   assign legacy_mode = st_reg.legacy_mode;
   assign error_nmi_en = st_reg.misc[0];
   assign discard_on_master_req = st_reg.pf[`BPCC_PF_DISCARD_ON_MASTER_REQ];
   assign discard_on_host_req = st_reg.pf[`BPCC_PF_DISCARD_ON_HOST_REQ];
   assign master_ok = (rd_master < 3'h5) && !master_prefetch_dis[rd_master];

   // Index 0 is the rising-edge register, index 1 the falling one; inner index 0 is bridge A.
   for (genvar r = 0; r < 2; r++)
   begin : g_comp
      for (genvar b = 0; b < 2; b++)
      begin : g_bridge
         logic [1:0] mode;
         logic [3:0] value;
         logic [4:0] sum;
         assign mode = (b == 0) ? st_reg.mode_a[r] : st_reg.mode_b[r];
         assign value = (b == 0) ? st_reg.val_a[r] : st_reg.val_b[r];
         assign sum = {1'b0, calc_s[r]} + {1'b0, value};
         always_comb
         begin
            case (mode)
               2'h0: drive_calc[r][b] = calc_s[r];
               2'h1: drive_calc[r][b] = value;
               2'h2: drive_calc[r][b] = sum[4] ? `BPCC_DRIVE_MAX : sum[3:0];
               default: drive_calc[r][b] = (calc_s[r] >= value) ? (calc_s[r] - value) : 4'h0;
            endcase
         end
      end
   end

   always_comb
   begin
      case (rd_cmd)
         bpcc_pkg::BPCC_CMD_MULTI:
         begin
            init_sel = st_reg.pf[`BPCC_PF_IPF_MULTI +: 3];
            cont_sel = st_reg.pf[`BPCC_PF_CPF_MULTI];
         end
         bpcc_pkg::BPCC_CMD_LINE:
         begin
            init_sel = st_reg.pf[`BPCC_PF_IPF_LINE +: 3];
            cont_sel = st_reg.pf[`BPCC_PF_CPF_LINE];
         end
         bpcc_pkg::BPCC_CMD_PLAIN:
         begin
            init_sel = st_reg.pf[`BPCC_PF_IPF_PLAIN +: 3];
            cont_sel = st_reg.pf[`BPCC_PF_CPF_PLAIN];
         end
         default:
         begin
            init_sel = 3'h0;
            cont_sel = 1'b0;
         end
      endcase
   end

   assign pf_stop = discard_on_master_req && other_master_req && st_reg.pf_active;

   always_comb
   begin
      st_next = st_reg;
      st_next.sync1 = pins_raw;
      st_next.sync2 = st_reg.sync1;
      st_next.pg_prev = pin_s.power_good;
      st_next.perr_prev = pin_s.perr_n;
      st_next.serr_prev = pin_s.serr_n;
      st_next.pfo = '0;
      st_next.rdata = 32'h0000_0000;

      // Straps are caught on the power-good rise so a slow supply ramp cannot latch garbage.
      if (pin_s.power_good && !st_reg.pg_prev)
      begin
         st_next.buffer_delay_value = pin_s.buffer_delay_value;
         st_next.hp_b = pin_s.hp_b;
         st_next.hp_a = pin_s.hp_a;
         st_next.compat = pin_s.compat;
      end

      if (reg_wr)
      begin
         case (reg_addr)
            `BPCC_OFF_LEGACY: st_next.legacy_mode = reg_wdata[0];
            `BPCC_OFF_MISC: st_next.misc = reg_wdata;
            `BPCC_OFF_STRAP: st_next.compat = reg_wdata[0];
            `BPCC_OFF_PREFETCH: st_next.pf = reg_wdata[13:0];
            `BPCC_OFF_RISE, `BPCC_OFF_FALL:
            begin
               st_next.top[reg_addr[2]] = reg_wdata[`BPCC_TOP_BIT];
               st_next.mode_b[reg_addr[2]] = reg_wdata[`BPCC_MODE_B_LSB +: 2];
               st_next.val_b[reg_addr[2]] = reg_wdata[`BPCC_VAL_B_LSB +: 4];
               st_next.mode_a[reg_addr[2]] = reg_wdata[`BPCC_MODE_A_LSB +: 2];
               st_next.val_a[reg_addr[2]] = reg_wdata[`BPCC_VAL_A_LSB +: 4];
            end
            default: ;
         endcase
      end

      if (reg_rd)
      begin
         case (reg_addr)
            `BPCC_OFF_LEGACY: st_next.rdata[0] = st_reg.legacy_mode;
            `BPCC_OFF_MISC: st_next.rdata = st_reg.misc;
            `BPCC_OFF_STRAP:
            begin
               st_next.rdata[`BPCC_BUFFER_DELAY_VALUE_LSB +: 4] = st_reg.buffer_delay_value;
               st_next.rdata[`BPCC_HPB_BIT] = st_reg.hp_b;
               st_next.rdata[`BPCC_HPA_BIT] = st_reg.hp_a;
               st_next.rdata[0] = st_reg.compat;
            end
            `BPCC_OFF_PREFETCH: st_next.rdata[13:0] = st_reg.pf;
            `BPCC_OFF_RISE, `BPCC_OFF_FALL:
            begin
               st_next.rdata[`BPCC_TOP_BIT] = st_reg.top[reg_addr[2]];
               st_next.rdata[`BPCC_CALC_LSB +: 4] = calc_s[reg_addr[2]];
               st_next.rdata[`BPCC_MODE_B_LSB +: 2] = st_reg.mode_b[reg_addr[2]];
               st_next.rdata[`BPCC_VAL_B_LSB +: 4] = st_reg.val_b[reg_addr[2]];
               st_next.rdata[`BPCC_MODE_A_LSB +: 2] = st_reg.mode_a[reg_addr[2]];
               st_next.rdata[`BPCC_VAL_A_LSB +: 4] = st_reg.val_a[reg_addr[2]];
            end
            default: ;
         endcase
      end

      // The peer bridge hands over its own already masked request term.
      st_next.irq_oe = ({4{legacy_mode}} & ~pin_s.irq_n & redir_mask_bit) | peer_irq_req;
      st_next.irq_out_n = 4'h0;
      st_next.nmi = error_nmi_en && ((st_reg.perr_prev && !pin_s.perr_n) ||
                                     (st_reg.serr_prev && !pin_s.serr_n));
      st_next.compat_fwd = st_reg.compat && host_compat_req;
      st_next.drive = drive_calc;

      // Prefetch engine: one cacheline request per cycle while any are pending.
      if (st_reg.pf_pending != 4'h0)
      begin
         st_next.pfo.line_req = 1'b1;
         st_next.pf_pending = st_reg.pf_pending - 4'h1;
      end
      if (st_reg.pf_active && st_reg.pf_cont && line_xfer_start && st_next.pf_pending != `BPCC_PEND_MAX)
      begin
         st_next.pf_pending = st_next.pf_pending + 4'h1;
      end
      if (st_reg.pf_active && bus_clk_tick)
      begin
         st_next.pf_timer = st_reg.pf_timer + 16'h0001;
      end
      if (line_xfer_start)
      begin
         st_next.pf_timer = 16'h0000;
         st_next.pf_short_done = 1'b0;
      end
      if (discard_on_master_req && st_reg.pf_active && !st_reg.pf_short_done &&
          st_reg.pf_timer >= `BPCC_DISCARD_SHORT)
      begin
         st_next.pfo.discard_unreq = 1'b1;
         st_next.pf_short_done = 1'b1;
      end
      if (pf_stop)
      begin
         st_next.pf_cont = 1'b0;
         st_next.pf_pending = 4'h0;
         st_next.pfo.discard_unreq = 1'b1;
      end
      if (discard_on_host_req && host_req && st_reg.pf_active)
      begin
         if (burst_active)
         begin
            st_next.host_wait_bound = 1'b1;
         end
         else if (requested_outstanding)
         begin
            st_next.host_wait_disc = 1'b1;
         end
         else
         begin
            st_next.pfo.discard_unreq = 1'b1;
            st_next.pf_cont = 1'b0;
            st_next.pf_pending = 4'h0;
         end
      end
      if (st_reg.host_wait_bound && line_boundary)
      begin
         st_next.pfo.burst_stop = 1'b1;
         st_next.pfo.discard_unreq = 1'b1;
         st_next.host_wait_bound = 1'b0;
         st_next.pf_cont = 1'b0;
         st_next.pf_pending = 4'h0;
      end
      if (st_reg.host_wait_disc && burst_disconnect)
      begin
         st_next.pfo.discard_unreq = 1'b1;
         st_next.host_wait_disc = 1'b0;
         st_next.pf_cont = 1'b0;
         st_next.pf_pending = 4'h0;
      end
      if (st_reg.pf_active && st_reg.pf_timer >= DISCARD_LONG)
      begin
         st_next.pfo.discard_all = 1'b1;
         st_next.pf_active = 1'b0;
         st_next.pf_cont = 1'b0;
         st_next.pf_pending = 4'h0;
         st_next.host_wait_bound = 1'b0;
         st_next.host_wait_disc = 1'b0;
      end
      // A new read other than BPCC_CMD_OTHER restarts the engine only in conventional mode; outside it the read starts no prefetch.
      if (rd_start && conv_pci_mode && rd_cmd != bpcc_pkg::BPCC_CMD_OTHER)
      begin
         st_next.pf_active = 1'b1;
         st_next.pf_timer = 16'h0000;
         st_next.pf_short_done = 1'b0;
         st_next.host_wait_bound = 1'b0;
         st_next.host_wait_disc = 1'b0;
         st_next.pf_cont = master_ok && cont_sel;
         st_next.pf_pending = master_ok ? ({1'b0, init_sel} + 4'h1) : 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.sync1.perr_n <= 1'b1;
         st_reg.sync2.perr_n <= 1'b1;
         st_reg.sync1.serr_n <= 1'b1;
         st_reg.sync2.serr_n <= 1'b1;
         st_reg.sync1.irq_n <= 4'hf;
         st_reg.sync2.irq_n <= 4'hf;
         st_reg.perr_prev <= 1'b1;
         st_reg.serr_prev <= 1'b1;
         st_reg.legacy_mode <= `BPCC_RST_LEGACY_MODE;
         st_reg.misc <= `BPCC_RST_MISC;
         st_reg.pf <= `BPCC_RST_PREFETCH;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign legacy_irq_out_n = st_reg.irq_out_n;
   assign legacy_irq_oe = st_reg.irq_oe;
   assign error_nmi = st_reg.nmi;
   assign compat_fwd = st_reg.compat_fwd;
   assign pf_out = st_reg.pfo;
   assign drive_rise_a = st_reg.drive[0][0];
   assign drive_rise_b = st_reg.drive[0][1];
   assign drive_fall_a = st_reg.drive[1][0];
   assign drive_fall_b = st_reg.drive[1][1];

   default clocking cb @(posedge core_clk iff clk_en);
   endclocking
   default disable iff (!rstn);

   sequence s_pg_rise;
      pin_s.power_good && !st_reg.pg_prev && !(reg_wr && reg_addr == `BPCC_OFF_STRAP);
   endsequence
   sequence s_batch_start;
      rd_start && conv_pci_mode && master_ok && rd_cmd == bpcc_pkg::BPCC_CMD_MULTI;
   endsequence
   sequence s_bound_hit;
      st_reg.host_wait_bound && line_boundary;
   endsequence
   sequence s_disc_hit;
      st_reg.host_wait_disc && burst_disconnect;
   endsequence

   a_irq_masked_off: assert property (!legacy_mode && peer_irq_req == 4'h0 |=> legacy_irq_oe == 4'h0)
      else $error("Legacy output driven while legacy mode is off.");
   a_irq_drive_low: assert property (legacy_mode && !pin_s.irq_n[0] && redir_mask_bit[0] |=> legacy_irq_oe[0])
      else $error("Enabled unmasked interrupt not driven.");
   a_od_never_high: assert property (legacy_irq_oe != 4'h0 |-> legacy_irq_out_n == 4'h0)
      else $error("Open-drain output drives high.");
   a_nmi_on_error: assert property (error_nmi_en && !(reg_wr && reg_addr == `BPCC_OFF_MISC) && $fell(pin_s.perr_n)
                                    |=> error_nmi)
      else $error("Parity error assertion gave no NMI.");
   a_strap_capture: assert property (s_pg_rise |=> st_reg.hp_b == $past(pin_s.hp_b) && st_reg.buffer_delay_value == $past(pin_s.buffer_delay_value))
      else $error("Strap values not latched at power-good.");
   a_pf_conv_only: assert property (rd_start && !conv_pci_mode && !st_reg.pf_active |=> !st_reg.pf_active)
      else $error("Prefetch started outside conventional mode.");
   a_pf_batch: assert property (s_batch_start |=>
                                st_reg.pf_pending == {1'b0, $past(st_reg.pf[`BPCC_PF_IPF_MULTI +: 3])} + 4'h1
                                ##1 pf_out.line_req)
      else $error("Initial prefetch batch size wrong.");
   a_master_stop: assert property (pf_stop && !rd_start |=> pf_out.discard_unreq && st_reg.pf_pending == 4'h0)
      else $error("Other master request did not stop prefetching.");
   a_comp_software: assert property (st_reg.mode_a[0] == 2'h1 && !reg_wr |=> drive_rise_a == $past(st_reg.val_a[0]))
      else $error("Software compensation value not applied.");
   a_irq_release: assert property (!redir_mask_bit[1] && !peer_irq_req[1] |=> !legacy_irq_oe[1])
      else $error("Masked interrupt output not released.");
   a_nmi_quiet: assert property (!error_nmi_en |=> !error_nmi)
      else $error("NMI raised while disabled.");
   a_compat_forward: assert property (host_compat_req && st_reg.compat |=> compat_fwd)
      else $error("Flagged host access not forwarded.");
   a_strap_hotplug: assert property (s_pg_rise |=> st_reg.hp_a == $past(pin_s.hp_a))
      else $error("Bridge A hot-plug strap not latched.");
   a_pf_timeout: assert property (st_reg.pf_active && st_reg.pf_timer >= DISCARD_LONG && !rd_start |=>
                                  pf_out.discard_all && !st_reg.pf_active)
      else $error("Long discard timeout missed.");
   a_host_discard: assert property (discard_on_host_req && host_req && st_reg.pf_active && !rd_start &&
                                    !burst_active && !requested_outstanding |=> pf_out.discard_unreq)
      else $error("Host request did not drop prefetches.");
   a_burst_stop: assert property (s_bound_hit |=> pf_out.burst_stop && pf_out.discard_unreq)
      else $error("Burst not ended at line boundary.");
   a_disc_drop: assert property (s_disc_hit |=> pf_out.discard_unreq)
      else $error("Prefetches not dropped at disconnect.");
endmodule

// *** verif/bpcc_top_test.sv ***
// Self-checking testbench for the bridge configuration block.
`timescale 1ns/1ps
module bpcc_top_test;
   logic core_clk, rstn, clk_en, reg_wr, reg_rd, power_good, hotplug_strap_b, hotplug_strap_a, compat_strap;
   logic perr_n, serr_n, error_nmi, host_compat_req, compat_fwd, conv_pci_mode, rd_start, line_xfer_start;
   logic bus_clk_tick, other_master_req, host_req, burst_active, requested_outstanding, burst_disconnect;
   logic line_boundary;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v, w;
   logic [3:0] buffer_delay_strap, pci_irq_in_n, redir_mask_bit, peer_irq_req, legacy_irq_out_n, legacy_irq_oe;
   logic [3:0] calc_drive_rise, calc_drive_fall, drive_rise_a, drive_rise_b, drive_fall_a, drive_fall_b;
   logic [4:0] master_prefetch_dis;
   logic [2:0] rd_master;
   bpcc_pkg::bpcc_cmd_t rd_cmd, c;
   bpcc_pkg::bpcc_pf_out_t pf_out;
   int failures, n_checks, seed, cyc, c_line, c_unreq, c_all, c_stop, c_nmi, c_fwd, n, lsb;

   // The long discard count is shortened so that the timeout path fits in the run.
   bpcc_top #(.DISCARD_LONG(16'h0028)) u_bpcc_top (.core_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .power_good, .buffer_delay_strap, .hotplug_strap_b, .hotplug_strap_a, .compat_strap,
      .pci_irq_in_n, .redir_mask_bit, .peer_irq_req, .legacy_irq_out_n, .legacy_irq_oe, .perr_n, .serr_n,
      .error_nmi, .host_compat_req, .compat_fwd, .conv_pci_mode, .master_prefetch_dis, .rd_start, .rd_cmd,
      .rd_master, .line_xfer_start, .bus_clk_tick, .other_master_req, .host_req, .burst_active,
      .requested_outstanding, .burst_disconnect, .line_boundary, .pf_out, .calc_drive_rise, .calc_drive_fall,
      .drive_rise_a, .drive_rise_b, .drive_fall_a, .drive_fall_b);

   always #50 core_clk = ~core_clk;

   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Pulse outputs are counted at the edge, where they still show the value of the cycle that ends.
   always @(posedge core_clk)
   begin
      cyc++;
      c_line += int'(pf_out.line_req !== 1'h0);
      c_unreq += int'(pf_out.discard_unreq !== 1'h0);
      c_all += int'(pf_out.discard_all !== 1'h0);
      c_stop += int'(pf_out.burst_stop !== 1'h0);
      c_nmi += int'(error_nmi !== 1'h0);
      c_fwd += int'(compat_fwd !== 1'h0);
      if (cyc == 30000)
      begin
         failures++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic clr();
      c_line = 0;
      c_unreq = 0;
      c_all = 0;
      c_stop = 0;
      c_nmi = 0;
      c_fwd = 0;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk($sformatf("reg_%h", a), e, reg_rdata);
   endtask

   task automatic start_rd(input bpcc_pkg::bpcc_cmd_t cm, input logic [2:0] m);
      @(posedge core_clk);
      rd_start <= 1'h1;
      rd_cmd <= cm;
      rd_master <= m;
      @(posedge core_clk);
      rd_start <= 1'h0;
      #1;
      clr();
   endtask

   task automatic pf_try(input logic cv, input bpcc_pkg::bpcc_cmd_t cm, input logic [2:0] m, input int e);
      @(posedge core_clk);
      conv_pci_mode <= cv;
      master_prefetch_dis <= 5'h02;
      start_rd(cm, m);
      tick(12);
      chk("lines", e, c_line);
      @(posedge core_clk);
      conv_pci_mode <= 1'h1;
   endtask

   task automatic hcase(input logic [31:0] pf, input logic ba, input logic ro, input int e_mid, input int e_end,
                        input int e_stop);
      @(posedge core_clk);
      burst_active <= ba;
      requested_outstanding <= ro;
      wr(8'h4c, pf);
      start_rd(bpcc_pkg::BPCC_CMD_MULTI, 3'h0);
      tick(8);
      clr();
      @(posedge core_clk);
      host_req <= 1'h1;
      @(posedge core_clk);
      host_req <= 1'h0;
      tick(4);
      chk("unreq_mid", e_mid, c_unreq);
      @(posedge core_clk);
      line_boundary <= ba;
      burst_disconnect <= ro;
      @(posedge core_clk);
      line_boundary <= 1'h0;
      burst_disconnect <= 1'h0;
      tick(4);
      chk("unreq_end", e_end, c_unreq);
      chk("stop", e_stop, c_stop);
      @(posedge core_clk);
      burst_active <= 1'h0;
      requested_outstanding <= 1'h0;
   endtask

   function automatic logic [3:0] comp(input logic [3:0] cv, input logic [1:0] m, input logic [3:0] d);
      logic [4:0] s;
      s = {1'h0, cv} + {1'h0, d};
      case (m)
         2'h0: comp = cv;
         2'h1: comp = d;
         2'h2: comp = s[4] ? 4'hf : s[3:0];
         default: comp = (cv < d) ? 4'h0 : cv - d;
      endcase
   endfunction

   initial
   begin
      seed = 14080;
      {core_clk, rstn, reg_wr, reg_rd, power_good, hotplug_strap_b, hotplug_strap_a, compat_strap} = '0;
      {host_compat_req, rd_start, line_xfer_start, bus_clk_tick, other_master_req, host_req} = '0;
      {burst_active, requested_outstanding, burst_disconnect, line_boundary, rd_master} = '0;
      {reg_addr, reg_wdata, buffer_delay_strap, redir_mask_bit, peer_irq_req, master_prefetch_dis} = '0;
      {clk_en, perr_n, serr_n, conv_pci_mode, pci_irq_in_n} = '1;
      rd_cmd = bpcc_pkg::BPCC_CMD_PLAIN;
      v = $random(seed);
      calc_drive_rise = v[3:0];
      calc_drive_fall = v[7:4];
      repeat (16) @(posedge core_clk);
      rstn <= 1'h1;
      tick(4);
      rdc(8'h40, 32'h0000_0001);
      rdc(8'h44, 32'h0000_0000);
      rdc(8'h4c, 32'h0000_2c00);
      rdc(8'h50, {12'h000, calc_drive_rise, 16'h0000});
      rdc(8'h54, {12'h000, calc_drive_fall, 16'h0000});
      chk("rise_a", calc_drive_rise, drive_rise_a);
      wr(8'h60, 32'hffff_ffff);
      rdc(8'h60, 32'h0000_0000);
      v = $random(seed);
      @(posedge core_clk);
      {buffer_delay_strap, hotplug_strap_b, hotplug_strap_a, compat_strap} <= v[6:0];
      tick(5);
      rdc(8'h48, 32'h0000_0000);
      @(posedge core_clk);
      power_good <= 1'h1;
      tick(6);
      rdc(8'h48, {20'h0_0000, v[6:3], 4'h0, v[2:1], 1'h0, v[0]});
      for (int b = 0; b < 2; b++)
      begin
         clr();
         wr(8'h48, {31'h7fff_ffff, b[0]});
         rdc(8'h48, {20'h0_0000, v[6:3], 4'h0, v[2:1], 1'h0, b[0]});
         @(posedge core_clk);
         host_compat_req <= 1'h1;
         @(posedge core_clk);
         host_compat_req <= 1'h0;
         tick(3);
         chk("fwd", b, c_fwd);
         clr();
      end
      repeat (4)
      begin
         v = $random(seed);
         wr(8'h44, v);
         rdc(8'h44, v);
         wr(8'h4c, v);
         rdc(8'h4c, v & 32'h0000_3fff);
      end
      // A write taken while the clock enable is low must leave the register untouched.
      @(posedge core_clk);
      clk_en <= 1'h0;
      wr(8'h44, ~v);
      clk_en <= 1'h1;
      rdc(8'h44, v);
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 32'h0000_0f01 : (i == 1) ? 32'h0000_0f00 : $random(seed);
         wr(8'h40, {31'h0000_0000, v[0]});
         pci_irq_in_n <= v[7:4];
         redir_mask_bit <= v[11:8];
         peer_irq_req <= v[15:12];
         tick(5);
         chk("irq_oe", ({4{v[0]}} & ~v[7:4] & v[11:8]) | v[15:12], legacy_irq_oe);
         chk("irq_out_n", 32'h0000_0000, legacy_irq_out_n);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h44, {31'h0000_0000, i[0]});
         clr();
         perr_n <= i[1];
         serr_n <= ~i[1];
         tick(5);
         @(posedge core_clk);
         {perr_n, serr_n} <= 2'h3;
         tick(5);
         chk("nmi", i[0], c_nmi);
      end
      for (int i = 0; i < 16; i++)
      begin
         v = $random(seed);
         w = {v[31:16], 1'h0, i[1:0], 1'h0, v[11:8], 1'h0, i[3:2], 1'h0, v[3:0]};
         w[31:15] = '0;
         wr(8'h50, w);
         wr(8'h54, w);
         calc_drive_rise <= (i == 0) ? 4'hf : v[19:16];
         calc_drive_fall <= (i == 0) ? 4'h0 : v[23:20];
         tick(6);
         chk("rise_a", comp(calc_drive_rise, w[6:5], w[3:0]), drive_rise_a);
         chk("rise_b", comp(calc_drive_rise, w[14:13], w[11:8]), drive_rise_b);
         chk("fall_a", comp(calc_drive_fall, w[6:5], w[3:0]), drive_fall_a);
         chk("fall_b", comp(calc_drive_fall, w[14:13], w[11:8]), drive_fall_b);
         rdc(8'h54, w | {12'h000, calc_drive_fall, 16'h0000});
      end
      for (int k = 0; k < 3; k++)
      begin
         v = $random(seed);
         c = (k == 0) ? bpcc_pkg::BPCC_CMD_PLAIN : (k == 1) ? bpcc_pkg::BPCC_CMD_LINE : bpcc_pkg::BPCC_CMD_MULTI;
         lsb = 2 + 4 * k;
         n = (k == 0) ? 7 : (k == 1) ? 0 : int'(v[2:0]);
         wr(8'h4c, (32'(n) << lsb) | (32'(v[3]) << (lsb + 3)));
         start_rd(c, 3'(v[6:4] % 5));
         tick(14);
         chk("lines", n + 1, c_line);
         clr();
         repeat (2)
         begin
            @(posedge core_clk);
            line_xfer_start <= 1'h1;
            @(posedge core_clk);
            line_xfer_start <= 1'h0;
         end
         tick(6);
         chk("cont", v[3] ? 2 : 0, c_line);
      end
      wr(8'h4c, 32'h0000_0800);
      pf_try(1'h0, bpcc_pkg::BPCC_CMD_MULTI, 3'h0, 0);
      pf_try(1'h1, bpcc_pkg::BPCC_CMD_OTHER, 3'h0, 0);
      pf_try(1'h1, bpcc_pkg::BPCC_CMD_MULTI, 3'h1, 1);
      pf_try(1'h1, bpcc_pkg::BPCC_CMD_MULTI, 3'h2, 3);
      wr(8'h4c, 32'h0000_1c02);
      start_rd(bpcc_pkg::BPCC_CMD_MULTI, 3'h0);
      @(posedge core_clk);
      other_master_req <= 1'h1;
      @(posedge core_clk);
      other_master_req <= 1'h0;
      tick(10);
      chk("unreq", 1, c_unreq);
      chk("cut", 1, c_line < 8);
      for (int d = 0; d < 2; d++)
      begin
         wr(8'h4c, {30'h0000_0000, d[0], 1'h0});
         start_rd(bpcc_pkg::BPCC_CMD_MULTI, 3'h0);
         @(posedge core_clk);
         bus_clk_tick <= 1'h1;
         tick(30);
         chk("all_early", 0, c_all);
         tick(15);
         chk("all", 1, c_all);
         chk("unreq_timer", d, c_unreq);
         @(posedge core_clk);
         bus_clk_tick <= 1'h0;
      end
      hcase(32'h0000_0001, 1'h0, 1'h0, 1, 1, 0);
      hcase(32'h0000_0001, 1'h1, 1'h0, 0, 1, 1);
      hcase(32'h0000_0001, 1'h0, 1'h1, 0, 1, 0);
      hcase(32'h0000_0000, 1'h1, 1'h1, 0, 0, 0);
      summarize();
   end
endmodule
